// File: rtl/sfr_map.vh
// constants for the serial flash read and status command logic
`ifndef SFR_MAP_VH
`define SFR_MAP_VH
// opcodes
`define SFR_OP_READ 8'h03
`define SFR_OP_FREAD 8'h0b
`define SFR_OP_STAT_RD 8'h05
`define SFR_OP_STAT_WR 8'h01
`define SFR_OP_WR_EN 8'h06
`define SFR_OP_WR_DIS 8'h04
`define SFR_OP_SSE_A 8'h20
`define SFR_OP_SSE_B 8'hd7
`define SFR_OP_SE 8'hd8
`define SFR_OP_CE 8'hc7
`define SFR_OP_PP 8'h02
// status field positions
`define SFR_ST_BUSY 0
`define SFR_ST_WEL 1
`define SFR_ST_PL_LO 2
`define SFR_ST_PL_HI 3
`define SFR_ST_LOCK 7
// nonvolatile field index inside the 3-bit store
`define SFR_NV_PL_LO 0
`define SFR_NV_PL_HI 1
`define SFR_NV_LOCK 2
`define SFR_NV_RESET 3'h0
// byte counts that complete each command (bytes already taken)
`define SFR_BC_ONE 3'h1
`define SFR_BC_SW 3'h2
`define SFR_BC_RD_LAST 3'h3
`define SFR_BC_FRD_LAST 3'h4
`define SFR_BC_ADDR 3'h4
`define SFR_BC_PP_MIN 3'h5
`define SFR_BC_MAX 3'h7
// array depth, 18-bit address wraps from top to zero
`define SFR_MEM_WORDS 262144
// internal write time in mclk cycles: 5000 us at a 10 MHz mclk
`define SFR_WR_CYCLES 20'd50000
`endif

// File: rtl/sfr_core.v
// serial flash command logic: array read, status read and write, write enable
`timescale 1ns/1ns
// Contract
// - opcode 03h plus 24-bit address returns array data from that address
// - 4-byte read drives first data bit on falling edge after address bit 0
// - fast read takes opcode 0Bh, 24-bit address, then 8 dummy bits
// - fast read output starts on falling edge after fifth byte bit 0
// - continued clocking increments byte address and outputs following data
// - address past 3FFFFh wraps to 00000h, output continues seamlessly
// - chip select high ends read; output stays high impedance while deselected
// - status byte: busy, write latch, two protect bits, zero bits, lock bit
// - status read accepted at any time, even during internal writes
// - after 05h status shifts out msb first from falling edge of bit 8
// - status output repeats from bit 7 until chip select rises
// - 01h plus one data byte starts status write at chip select rise
// - status write changes only protect bits and lock bit
// - protect and lock bits are nonvolatile, restored at power-on
// - status write does its own erase and program internally
// - busy reads 1 during internal write, 0 once complete
// - write latch 0 blocks erase, program and status write commands
// - 06h sets write latch, 04h clears it
// - write latch clears at power-on and on write completion, except when 06h ends in that same cycle
// - rejected write keeps write latch; reads never change it
// - non-read commands count only if chip select rises after whole bytes
// - input msb first on rising clock; output driven on falling clock
// - lock bit 1 with write guard low makes status write ignored
`include "sfr_map.vh"

module sfr_core #(
  parameter [19:0] WR_CYCLES = `SFR_WR_CYCLES
) (
  input wire mclk,
  input wire srst,
  input wire sck,
  input wire cs_n,
  input wire si,
  input wire wp_n,
  input wire [2:0] nv_boot,
  input wire load_en,
  input wire [17:0] load_addr,
  input wire [7:0] load_data,
  output reg so,
  output reg so_oe,
  output reg [2:0] nv_store
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_CMD = 5'h02;
  localparam [4:0] ST_ARG = 5'h04;
  localparam [4:0] ST_RDAT = 5'h08;
  localparam [4:0] ST_SDAT = 5'h10;

  reg [7:0] mem [0:`SFR_MEM_WORDS-1];
  reg sck_s1, sck_s2, sck_d;
  reg cs_s1, cs_s2, cs_d;
  reg si_s1, si_s2;
  reg wp_s1, wp_s2;
  reg [4:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [2:0] byte_cnt_reg;
  reg [7:0] sh_in_reg;
  reg [7:0] op_reg;
  reg [23:0] addr_reg;
  reg [17:0] rd_addr_reg;
  reg [7:0] fifo_mem [0:1];
  reg fifo_wp_reg, fifo_rp_reg;
  reg [1:0] fifo_cnt_reg;
  reg [2:0] obit_reg;
  reg [6:0] osh_reg;
  reg [2:0] nv_reg;
  reg nv_loaded_reg;
  reg wen_reg;
  reg busy_reg;
  reg sw_pend_reg;
  reg [2:0] sw_data_reg;
  reg [19:0] wr_cnt_reg;

  // protect level against address bits a17:a16
  function prot_hit;
    input [1:0] lvl;
    input [1:0] a;
    begin
      case (lvl)
        2'h1: prot_hit = a[1] & a[0];
        2'h2: prot_hit = a[1];
        2'h3: prot_hit = 1'b1;
        default: prot_hit = 1'b0;
      endcase
    end
  endfunction

  // two-stage synchronisers, plus a third stage for edge finding
  always @(posedge mclk) begin
    if (srst) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      si_s1 <= 1'b0;
      si_s2 <= 1'b0;
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
    end else begin
      sck_s1 <= sck;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      si_s1 <= si;
      si_s2 <= si_s1;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
    end
  end

  // si shares the clock's sync depth, so it lines up with the rising edge
  wire sck_rise = sck_s2 & ~sck_d & ~cs_s2;
  wire sck_fall = ~sck_s2 & sck_d & ~cs_s2;
  wire cs_fall = ~cs_s2 & cs_d;
  wire cs_rise = cs_s2 & ~cs_d;
  wire [7:0] in_byte = {sh_in_reg[6:0], si_s2};
  wire byte_done = sck_rise & (bit_cnt_reg == 3'h7);

  wire [7:0] stat = {nv_reg[`SFR_NV_LOCK], 3'h0, nv_reg[`SFR_NV_PL_HI],
                     nv_reg[`SFR_NV_PL_LO], wen_reg, busy_reg};

  // read starts once the last address byte is in
  // fast read waits for the dummy byte as well
  wire start_rd = byte_done & (state_reg == ST_ARG) &
                  (((op_reg == `SFR_OP_READ) & (byte_cnt_reg == `SFR_BC_RD_LAST)) |
                   ((op_reg == `SFR_OP_FREAD) & (byte_cnt_reg == `SFR_BC_FRD_LAST)));

  // only whole-byte commands ending in chip select rise are taken
  wire aligned = cs_rise & (state_reg == ST_ARG) & (bit_cnt_reg == 3'h0);
  wire one_byte = aligned & (byte_cnt_reg == `SFR_BC_ONE);
  // writes need the latch and an idle array
  wire may_wr = wen_reg & ~busy_reg;
  wire hit = prot_hit(nv_reg[`SFR_NV_PL_HI:`SFR_NV_PL_LO], addr_reg[17:16]);
  // locked status with guard low refuses the status write
  wire sw_go = aligned & (op_reg == `SFR_OP_STAT_WR) & (byte_cnt_reg == `SFR_BC_SW) &
               may_wr & ~(nv_reg[`SFR_NV_LOCK] & ~wp_s2);
  wire er_go = aligned & (byte_cnt_reg == `SFR_BC_ADDR) & may_wr & ~hit &
               ((op_reg == `SFR_OP_SSE_A) | (op_reg == `SFR_OP_SSE_B) |
                (op_reg == `SFR_OP_SE));
  wire ce_go = one_byte & (op_reg == `SFR_OP_CE) & may_wr &
               (nv_reg[`SFR_NV_PL_HI:`SFR_NV_PL_LO] == 2'h0);
  wire pp_go = aligned & (op_reg == `SFR_OP_PP) & (byte_cnt_reg >= `SFR_BC_PP_MIN) &
               may_wr & ~hit;
  wire wr_go = sw_go | er_go | ce_go | pp_go;
  wire wr_done = busy_reg & (wr_cnt_reg == 20'h0);

  // command decoder and input shifter
  always @(posedge mclk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      sh_in_reg <= 8'h00;
      op_reg <= 8'h00;
      addr_reg <= 24'h000000;
    end else if (cs_s2) begin
      state_reg <= ST_IDLE;
    end else if (cs_fall) begin
      state_reg <= ST_CMD;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
    end else if (sck_rise) begin
      // msb first on the rising edge
      sh_in_reg <= in_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        if (byte_cnt_reg != `SFR_BC_MAX)
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
        case (state_reg)
          ST_CMD: begin
            op_reg <= in_byte;
            // status read decoded whatever the busy state
            if (in_byte == `SFR_OP_STAT_RD)
              state_reg <= ST_SDAT;
            else
              state_reg <= ST_ARG;
          end
          ST_ARG: begin
            // address bytes, or the status write data byte, shift in here
            if (byte_cnt_reg < `SFR_BC_ADDR)
              addr_reg <= {addr_reg[15:0], in_byte};
            if (start_rd)
              state_reg <= ST_RDAT;
          end
          default: state_reg <= state_reg;
        endcase
      end
    end
  end

  // preload port for array contents, same clock as the core
  always @(posedge mclk) begin
    if (load_en)
      mem[load_addr] <= load_data;
  end

  // two-entry read buffer; the fetch stalls whenever both entries are held
  wire fifo_full = (fifo_cnt_reg == 2'h2);
  wire fifo_valid = (fifo_cnt_reg != 2'h0);
  wire push = (state_reg == ST_RDAT) & ~fifo_full;
  wire pop = sck_fall & (state_reg == ST_RDAT) & (obit_reg == 3'h0) & fifo_valid;
  always @(posedge mclk) begin
    if (srst) begin
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
      rd_addr_reg <= 18'h00000;
    end else if (start_rd) begin
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
      if (op_reg == `SFR_OP_READ)
        rd_addr_reg <= {addr_reg[9:0], in_byte};
      else
        rd_addr_reg <= addr_reg[17:0];
    end else begin
      if (push) begin
        fifo_mem[fifo_wp_reg] <= mem[rd_addr_reg];
        fifo_wp_reg <= ~fifo_wp_reg;
        // address steps on, 18 bits wrap top to zero
        rd_addr_reg <= rd_addr_reg + 18'h00001;
      end
      if (pop)
        fifo_rp_reg <= ~fifo_rp_reg;
      if (push & ~pop)
        fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
      else if (pop & ~push)
        fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
    end
  end

  // an empty buffer cannot occur at clock rates in range; ones are sent if it does
  wire [7:0] obyte = (state_reg == ST_SDAT) ? stat :
                     (fifo_valid ? fifo_mem[fifo_rp_reg] : 8'hff);

  // serial output shifter
  always @(posedge mclk) begin
    if (srst) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      obit_reg <= 3'h0;
      osh_reg <= 7'h00;
    end else if (cs_s2 | cs_fall) begin
      so_oe <= 1'b0;
      obit_reg <= 3'h0;
    end else if (sck_fall & ((state_reg == ST_RDAT) | (state_reg == ST_SDAT))) begin
      // first bit on the falling edge after the last input bit
      so_oe <= 1'b1;
      obit_reg <= obit_reg + 3'h1;
      if (obit_reg == 3'h0) begin
        // status is reloaded afresh every eight bits
        so <= obyte[7];
        osh_reg <= obyte[6:0];
      end else begin
        so <= osh_reg[6];
        osh_reg <= {osh_reg[5:0], 1'b0};
      end
    end
  end

  // internal write timer covers erase and program steps
  always @(posedge mclk) begin
    if (srst) begin
      busy_reg <= 1'b0;
      sw_pend_reg <= 1'b0;
      sw_data_reg <= 3'h0;
      wr_cnt_reg <= 20'h0;
    end else if (wr_go) begin
      busy_reg <= 1'b1;
      sw_pend_reg <= sw_go;
      // new bits held here, so a command sent while busy cannot disturb them
      sw_data_reg <= {addr_reg[`SFR_ST_LOCK], addr_reg[`SFR_ST_PL_HI],
                      addr_reg[`SFR_ST_PL_LO]};
      wr_cnt_reg <= WR_CYCLES - 20'h1;
    end else if (busy_reg) begin
      if (wr_cnt_reg == 20'h0)
        busy_reg <= 1'b0;
      else
        wr_cnt_reg <= wr_cnt_reg - 20'h1;
    end
  end

  // write latch; a command edge wins over a completion in the same cycle
  always @(posedge mclk) begin
    if (srst) begin
      wen_reg <= 1'b0;
    end else if (one_byte & (op_reg == `SFR_OP_WR_EN)) begin
      wen_reg <= 1'b1;
    end else if (one_byte & (op_reg == `SFR_OP_WR_DIS)) begin
      wen_reg <= 1'b0;
    end else if (wr_done) begin
      // cleared only by a write that really ran
      wen_reg <= 1'b0;
    end
  end

  // nonvolatile bits: restored from the store after reset, written back out
  always @(posedge mclk) begin
    if (srst) begin
      nv_reg <= `SFR_NV_RESET;
      nv_loaded_reg <= 1'b0;
      nv_store <= `SFR_NV_RESET;
    end else begin
      if (~nv_loaded_reg) begin
        nv_reg <= nv_boot;
        nv_loaded_reg <= 1'b1;
      end else if (wr_done & sw_pend_reg) begin
        // only protect and lock bits take the new byte
        nv_reg <= sw_data_reg;
      end
      nv_store <= nv_reg;
    end
  end

endmodule

// File: verification/sfr_core_assertions.sv
// port checker for the serial flash command logic
`timescale 1ns/1ns
module sfr_core_assertions (
  input wire mclk,
  input wire srst,
  input wire sck,
  input wire cs_n,
  input wire wp_n,
  input wire [2:0] nv_boot,
  input wire so,
  input wire so_oe,
  input wire [2:0] nv_store
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // reset keeps the pin released and the store image cleared
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !so_oe && nv_store == 3'h0)
    else $error("outputs not quiet in reset");
  a_boot_load: assert property ($fell(srst) |-> ##2 nv_store == $past(nv_boot, 2))
    else $error("boot image not restored");
  a_oe_off_desel: assert property (cs_n [*4] |-> !so_oe)
    else $error("so driven while deselected");
  a_oe_holds: assert property (so_oe && !cs_n && !$past(cs_n) |=> so_oe)
    else $error("output dropped during select");
  a_oe_after_sel: assert property ($rose(so_oe) |-> $past(cs_n, 2) == 1'b0)
    else $error("output without select");
  a_first_bit_fall: assert property ($rose(so_oe) |-> !sck && !$past(sck))
    else $error("first bit not after falling clock");
  a_so_on_fall: assert property (so_oe && $past(so_oe) && $changed(so) |-> !$past(sck))
    else $error("so moved outside clock low phase");
  a_lock_holds: assert property ((nv_store[2] && !wp_n) [*8] |=> $stable(nv_store))
    else $error("locked bits changed");
  c_out: cover property ($rose(so_oe));
  c_nv: cover property ($changed(nv_store));
  c_lock: cover property (nv_store[2] && !wp_n);
endmodule
bind sfr_core sfr_core_assertions sfr_core_assertions_inst (.mclk(mclk), .srst(srst),
  .sck(sck), .cs_n(cs_n), .wp_n(wp_n), .nv_boot(nv_boot), .so(so), .so_oe(so_oe),
  .nv_store(nv_store));

// File: verification/sfr_host.sv
// host spi controller model, mode 0, clock idle low between frames
`timescale 1ns/1ns
module sfr_host (
  input wire mclk,
  input wire so_w,
  output reg sck,
  output reg cs_n,
  output reg si
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // select with setup ahead of the first rise
  task sel;
    begin
      @(posedge mclk) cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  // rise chip select only after whole bytes
  task desel;
    begin
      repeat (4) @(posedge mclk);
      cs_n <= 1'b1;
      repeat (8) @(posedge mclk);
    end
  endtask
  // msb first, si moves while sck low, so taken at the rise
  task xbyte(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        si <= tx[i];
        repeat (4) @(posedge mclk);
        sck <= 1'b1;
        rx[i] = so_w;
        repeat (4) @(posedge mclk);
        sck <= 1'b0;
      end
    end
  endtask
endmodule

// File: verification/sfr_core_tb.sv
// self-checking bench for the serial flash command logic
`timescale 1ns/1ns
`include "sfr_map.vh"
module sfr_core_tb;
  localparam [19:0] WR_N = 20'd400;
  reg mclk, srst, wp_n, load_en;
  reg [2:0] nv_boot;
  reg [17:0] load_addr;
  reg [7:0] load_data;
  wire sck, cs_n, si, so, so_oe;
  wire [2:0] nv_store;
  integer error_cnt = 0;
  integer num_checks = 0;
  integer cyc = 0;
  reg [7:0] r;
  // released wire shows the inverse so a stale bit never passes
  wire so_w = so_oe ? so : ~so;
  sfr_core #(.WR_CYCLES(WR_N)) sfr_core_inst (.mclk(mclk), .srst(srst), .sck(sck),
    .cs_n(cs_n), .si(si), .wp_n(wp_n), .nv_boot(nv_boot), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .so(so), .so_oe(so_oe),
    .nv_store(nv_store));
  sfr_host sfr_host_inst (.mclk(mclk), .so_w(so_w), .sck(sck), .cs_n(cs_n), .si(si));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // hang guard, well above the roughly 8700 cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task check(input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  function [7:0] dat(input [17:0] a);
    dat = a[7:0] ^ {6'h0, a[17:16]} ^ 8'h3c;
  endfunction
  task load(input [17:0] a);
    begin
      @(posedge mclk);
      load_en <= 1'b1;
      load_addr <= a;
      load_data <= dat(a);
      @(posedge mclk);
      load_en <= 1'b0;
    end
  endtask
  // array read of four bytes per select; the 03h call crosses the top address
  task t_read(input [7:0] op, input [23:0] a24);
    reg [17:0] a;
    integer i;
    begin
      sfr_host_inst.sel;
      // opcode, three address bytes, dummy for fast read
      sfr_host_inst.xbyte(op, r);
      sfr_host_inst.xbyte(a24[23:16], r);
      sfr_host_inst.xbyte(a24[15:8], r);
      sfr_host_inst.xbyte(a24[7:0], r);
      if (op == `SFR_OP_FREAD)
        sfr_host_inst.xbyte(8'ha5, r);
      for (i = 0; i < 4; i = i + 1) begin
        a = a24[17:0] + i[17:0];
        sfr_host_inst.xbyte(8'h00, r);
        check(r, dat(a));
      end
      sfr_host_inst.desel;
      check({7'h0, so_oe}, 8'h00);
    end
  endtask
  // status read of two bytes, the second a repeat of the first
  task rd_stat(input [7:0] exp);
    begin
      sfr_host_inst.sel;
      sfr_host_inst.xbyte(`SFR_OP_STAT_RD, r);
      sfr_host_inst.xbyte(8'hff, r);
      check(r, exp);
      sfr_host_inst.xbyte(8'h00, r);
      check(r, exp);
      sfr_host_inst.desel;
    end
  endtask
  task wr_cmd(input [7:0] op, input more, input [7:0] d);
    begin
      sfr_host_inst.sel;
      sfr_host_inst.xbyte(op, r);
      if (more)
        sfr_host_inst.xbyte(d, r);
      sfr_host_inst.desel;
    end
  endtask
  // four-byte erase or five-byte program command at address zero
  task wr_addr(input [7:0] op, input data);
    begin
      sfr_host_inst.sel;
      sfr_host_inst.xbyte(op, r);
      repeat (3) sfr_host_inst.xbyte(8'h00, r);
      if (data)
        sfr_host_inst.xbyte(8'h5a, r);
      sfr_host_inst.desel;
    end
  endtask
  // latch set, cleared, untouched by reads and by an overlong command
  task t_wel;
    begin
      rd_stat(8'h08);
      wr_cmd(`SFR_OP_WR_EN, 1'b0, 8'h00);
      rd_stat(8'h0a);
      rd_stat(8'h0a);
      wr_cmd(`SFR_OP_WR_DIS, 1'b0, 8'h00);
      rd_stat(8'h08);
      wr_cmd(`SFR_OP_WR_EN, 1'b1, 8'h00);
      rd_stat(8'h08);
    end
  endtask
  // status write refused, accepted with one busy read and a fixed wait, then locked out
  task t_swr;
    begin
      wr_cmd(`SFR_OP_STAT_WR, 1'b1, 8'hff);
      rd_stat(8'h08);
      // write guard high and latch set before the write
      wr_cmd(`SFR_OP_WR_EN, 1'b0, 8'h00);
      wr_cmd(`SFR_OP_STAT_WR, 1'b1, 8'hff);
      rd_stat(8'h0b);
      repeat (WR_N + 50) @(posedge mclk);
      rd_stat(8'h8c);
      check({5'h0, nv_store}, 8'h07);
      wp_n <= 1'b0;
      wr_cmd(`SFR_OP_WR_EN, 1'b0, 8'h00);
      wr_cmd(`SFR_OP_STAT_WR, 1'b1, 8'h00);
      repeat (WR_N + 50) @(posedge mclk);
      rd_stat(8'h8e);
      check({5'h0, nv_store}, 8'h07);
    end
  endtask
  // erase refused while protected keeps the latch; unprotect, then program and erase run
  task t_erase;
    begin
      wr_cmd(`SFR_OP_CE, 1'b0, 8'h00);
      rd_stat(8'h8e);
      wr_addr(`SFR_OP_SE, 1'b0);
      rd_stat(8'h8e);
      wp_n <= 1'b1;
      wr_cmd(`SFR_OP_STAT_WR, 1'b1, 8'h00);
      repeat (WR_N + 50) @(posedge mclk);
      rd_stat(8'h00);
      check({5'h0, nv_store}, 8'h00);
      wr_cmd(`SFR_OP_WR_EN, 1'b0, 8'h00);
      wr_addr(`SFR_OP_PP, 1'b1);
      rd_stat(8'h03);
      repeat (WR_N + 50) @(posedge mclk);
      rd_stat(8'h00);
      wr_cmd(`SFR_OP_WR_EN, 1'b0, 8'h00);
      wr_cmd(`SFR_OP_CE, 1'b0, 8'h00);
      rd_stat(8'h03);
      repeat (WR_N + 50) @(posedge mclk);
      rd_stat(8'h00);
    end
  endtask
  initial begin
    srst = 1'b1;
    wp_n = 1'b1;
    nv_boot = 3'h2;
    load_en = 1'b0;
    load_addr = 18'h0;
    load_data = 8'h00;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    load(18'h3fffe);
    load(18'h3ffff);
    load(18'h00000);
    load(18'h00001);
    load(18'h00123);
    load(18'h00124);
    load(18'h00125);
    load(18'h00126);
    t_read(`SFR_OP_READ, 24'h03fffe);
    t_read(`SFR_OP_FREAD, 24'hfc0123);
    t_wel;
    t_swr;
    t_erase;
    wrap_up;
  end
endmodule
